// file: hw/vmu_cfg.svh
`ifndef VMU_CFG_SVH
`define VMU_CFG_SVH

// ----------------------------------------
// register map (byte offsets)
// ----------------------------------------
`define VMU_OFF_CTL 8'h00
`define VMU_OFF_RST 8'h04
`define VMU_OFF_STAT 8'h08
`define VMU_OFF_TW0 8'h10
`define VMU_OFF_TWL 8'h44
`define VMU_TW_N 14
`define VMU_TW_OFS0 9
`define VMU_TW_CLIP 12
`define VMU_TW_CLAMP 13

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define VMU_CTL_EN 0
`define VMU_CTL_UPD 1
`define VMU_RST_MAN 0
`define VMU_RST_AUTO 1
`define VMU_CTL_DEF 2'h1
`define VMU_K_ONE 16'h2000
`define VMU_CLIP_DEF 16'h0FFF
`define VMU_FULL_STRB 4'hF
`define VMU_RESP_OK 2'h0
`define VMU_RESP_ERR 2'h2

// ----------------------------------------
// datapath and timing
// ----------------------------------------
`define VMU_IW 8
`define VMU_OW 12
`define VMU_KFRAC 13
// gain of four from the narrow input to the wide output, not the full bit difference
`define VMU_SCALE_LOG2 2
`define VMU_SCALE_SH (`VMU_KFRAC - `VMU_SCALE_LOG2)
`define VMU_LAT 7
`define VMU_EVAL_HOURS 8
`define VMU_CLK_HZ 20000000
`define VMU_EVAL_CYC (64'd`VMU_EVAL_HOURS * 64'd3600 * 64'd`VMU_CLK_HZ)
`endif

// file: hw/vmu_pkg.sv
package vmu_pkg;
    // run, held in reset, waiting for the frame edge
    typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_RESYNC} vmu_state_t;
endpackage

// file: hw/vmu_dly.sv
`timescale 1ns/1ns
module vmu_dly #(
    parameter int W = 3,
    parameter int D = 2
) (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [D-1:0][W-1:0] sr_r;

    // shift only on enabled clocks so the delay counts pixels, not clocks
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            sr_r <= '0;
        end else if (ce_i) begin
            sr_r <= {sr_r[D-2:0], d_i};
        end
    end

    assign q_o = sr_r[D-1];
endmodule

// file: hw/vmu_top.sv
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
`include "vmu_cfg.svh"
module vmu_top #(
    parameter logic [39:0] EVAL_CYCLES = 40'(`VMU_EVAL_CYC),
    parameter logic EVAL_BUILD = 1'b1
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [`VMU_IW-1:0] pix_r_i,
    input wire logic [`VMU_IW-1:0] pix_g_i,
    input wire logic [`VMU_IW-1:0] pix_b_i,
    input wire logic hblank_i,
    input wire logic vblank_i,
    input wire logic active_video_i,
    output logic [`VMU_OW-1:0] pix_r_o,
    output logic [`VMU_OW-1:0] pix_g_o,
    output logic [`VMU_OW-1:0] pix_b_o,
    output logic hblank_o,
    output logic vblank_o,
    output logic active_video_o,
    output vmu_pkg::vmu_state_t state_o,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    import vmu_pkg::*;

    localparam int N = `VMU_TW_N;
    localparam int OW = `VMU_OW;

    vmu_state_t state_r;
    vmu_state_t state_nxt;
    logic [1:0] ctl_r;
    logic [1:0] rst_r;
    logic [N-1:0][15:0] tw_stg;
    logic [N-1:0][15:0] tw_act;
    logic [39:0] eval_cnt_r;
    logic expired_r;
    logic vb_prev_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [2:0][`VMU_IW-1:0] px_r;
    logic [3*OW-1:0] px_s4;
    logic [3*OW-1:0] px_q;
    logic [2:0] sync_q;

    // ----------------------------------------
    // frame edge, reset request and apply strobe
    // ----------------------------------------
    wire vb_rise = ce_i & vblank_i & ~vb_prev_r;
    // auto reset waits for a frame edge so the picture does not tear
    wire hold_now = rst_r[`VMU_RST_MAN]
                  | (rst_r[`VMU_RST_AUTO] & (vb_rise | (state_r == ST_HOLD)));
    wire apply_w = ctl_r[`VMU_CTL_EN] & ctl_r[`VMU_CTL_UPD] & vb_rise & ~hold_now;
    wire zero_w = hold_now | (state_r != ST_RUN) | expired_r;

    // vblank history advances with the pixel stream only
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            vb_prev_r <= 1'b0;
        end else if (ce_i) begin
            vb_prev_r <= vblank_i;
        end
    end

    // ----------------------------------------
    // reset and resync sequencing
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (hold_now) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!hold_now) begin
                    state_nxt = ST_RESYNC;
                end
            end
            ST_RESYNC: begin
                if (hold_now) begin
                    state_nxt = ST_HOLD;
                end else if (vb_rise) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
    end

    // a clear also resyncs, so the first frame out is a whole one
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= ST_RESYNC;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign state_o = state_r;

    // ----------------------------------------
    // evaluation timer
    // ----------------------------------------
    // sticky until the synchronous clear; 40 bits cover eight hours at 20 MHz
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            eval_cnt_r <= 40'h0;
            expired_r <= 1'b0;
        end else if (EVAL_BUILD && !expired_r) begin
            eval_cnt_r <= eval_cnt_r + 40'h1;
            expired_r <= (eval_cnt_r >= EVAL_CYCLES - 40'h1);
        end
    end

    // ----------------------------------------
    // register bus: write side
    // ----------------------------------------
    wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
    wire w_take = s_axi_wvalid_i & s_axi_wready_o;
    wire b_done = s_axi_bvalid_o & s_axi_bready_i;
    wire wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid_o;
    wire [7:0] wa = {waddr_r[7:2], 2'b00};
    wire w_tw = (wa >= `VMU_OFF_TW0) && (wa <= `VMU_OFF_TWL);
    wire w_hit = (wa == `VMU_OFF_CTL) || (wa == `VMU_OFF_RST) || (wa == `VMU_OFF_STAT) || w_tw;
    // partial words are answered but dropped
    wire wr_ok = wr_go & (wstrb_r == `VMU_FULL_STRB);
    wire wr_ctl = wr_ok & (wa == `VMU_OFF_CTL);
    wire wr_rst = wr_ok & (wa == `VMU_OFF_RST);
    wire [7:0] wtw = wa - `VMU_OFF_TW0;

    // address and data are taken in either order and held until the answer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aw_hold_r <= 1'b0;
            waddr_r <= 8'h00;
        end else if (aw_take) begin
            aw_hold_r <= 1'b1;
            waddr_r <= s_axi_awaddr_i;
        end else if (b_done) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            w_hold_r <= 1'b0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
        end else if (w_take) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
        end else if (b_done) begin
            w_hold_r <= 1'b0;
        end
    end

    // ready drops for the whole transaction, one write at a time
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
        end else begin
            s_axi_awready_o <= ~aw_hold_r & ~aw_take;
            s_axi_wready_o <= ~w_hold_r & ~w_take;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `VMU_RESP_OK;
        end else if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= w_hit ? `VMU_RESP_OK : `VMU_RESP_ERR;
        end else if (b_done) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // control and reset registers
    // ----------------------------------------
    // update bit only moves while enabled; reset puts control back to defaults
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || hold_now) begin
            ctl_r <= `VMU_CTL_DEF;
        end else if (wr_ctl) begin
            ctl_r[`VMU_CTL_EN] <= wdata_r[`VMU_CTL_EN];
            if (ctl_r[`VMU_CTL_EN]) begin
                ctl_r[`VMU_CTL_UPD] <= wdata_r[`VMU_CTL_UPD];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rst_r <= 2'h0;
        end else if (wr_rst) begin
            rst_r <= wdata_r[1:0];
        end
    end

    // ----------------------------------------
    // staged and live tuning words
    // ----------------------------------------
    // order: k11..k33, r/g/b offset, clip, clamp
    for (genvar i = 0; i < N; i++) begin : g_tw
        logic [15:0] stg_r;
        logic [15:0] act_r;
        wire [15:0] def_w = (i == 0 || i == 4 || i == 8) ? `VMU_K_ONE :
                            (i == `VMU_TW_CLIP) ? `VMU_CLIP_DEF : 16'h0000;
        wire hit_w = wr_ok & w_tw & (wtw[5:2] == 4'(i));

        // live copies only move on the frame edge or while reset is held, all in the same cycle
        always_ff @(posedge clk_i) begin
            if (sys_rst_i || hold_now) begin
                stg_r <= def_w;
                act_r <= def_w;
            end else begin
                if (hit_w) begin
                    stg_r <= wdata_r[15:0];
                end
                if (apply_w) begin
                    act_r <= stg_r;
                end
            end
        end

        assign tw_stg[i] = stg_r;
        assign tw_act[i] = act_r;
    end

    // ----------------------------------------
    // register bus: read side
    // ----------------------------------------
    wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
    wire [7:0] ra = {s_axi_araddr_i[7:2], 2'b00};
    wire r_tw = (ra >= `VMU_OFF_TW0) && (ra <= `VMU_OFF_TWL);
    wire [7:0] rtw = ra - `VMU_OFF_TW0;
    wire [3:0] stat_w = {state_r == ST_RUN, expired_r, state_r == ST_RESYNC, state_r == ST_HOLD};
    wire r_hit = (ra == `VMU_OFF_CTL) || (ra == `VMU_OFF_RST) || (ra == `VMU_OFF_STAT) || r_tw;
    wire [31:0] rd_w = (ra == `VMU_OFF_CTL) ? {30'h0, ctl_r} :
                       (ra == `VMU_OFF_RST) ? {30'h0, rst_r} :
                       (ra == `VMU_OFF_STAT) ? {28'h0, stat_w} :
                       r_tw ? {16'h0, tw_stg[rtw[5:2]]} : 32'h0;

    // read data is captured at the address edge and held until taken
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0;
            s_axi_rresp_o <= `VMU_RESP_OK;
        end else if (ar_take) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_w;
            s_axi_rresp_o <= r_hit ? `VMU_RESP_OK : `VMU_RESP_ERR;
        end else begin
            s_axi_rvalid_o <= s_axi_rvalid_o & ~s_axi_rready_i;
            s_axi_arready_o <= ~s_axi_rvalid_o | s_axi_rready_i;
        end
    end

    // ----------------------------------------
    // pixel datapath: input, product, sum, offset and limit
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            px_r <= {pix_b_i, pix_g_i, pix_r_i};
        end
    end

    for (genvar c = 0; c < 3; c++) begin : g_ch
        logic signed [2:0][24:0] prod_r;
        logic signed [26:0] sum_r;
        logic [OW-1:0] res_r;
        // fractional bits minus the two-bit gain step leaves a gain of four, not the full output width
        wire signed [26:0] scl_w = sum_r >>> `VMU_SCALE_SH;
        wire signed [26:0] ofs_w = 27'($signed(tw_act[`VMU_TW_OFS0 + c][12:0]));
        wire signed [26:0] sumo_w = scl_w + ofs_w;
        wire signed [26:0] clip_w = $signed({15'h0, tw_act[`VMU_TW_CLIP][11:0]});
        wire signed [26:0] clamp_w = $signed({15'h0, tw_act[`VMU_TW_CLAMP][11:0]});
        wire signed [26:0] lo_w = (sumo_w > clip_w) ? clip_w : sumo_w;
        wire signed [26:0] fin_w = (lo_w < clamp_w) ? clamp_w : lo_w;

        // three register stages; all freeze together when ce is low
        always_ff @(posedge clk_i) begin
            if (ce_i) begin
                for (int j = 0; j < 3; j++) begin
                    prod_r[j] <= $signed(tw_act[3*c+j]) * $signed({1'b0, px_r[j]});
                end
                // an element of a packed array is unsigned, so sign it before widening
                sum_r <= 27'($signed(prod_r[0])) + 27'($signed(prod_r[1])) + 27'($signed(prod_r[2]));
                res_r <= fin_w[OW-1:0];
            end
        end

        assign px_s4[c*OW +: OW] = res_r;
    end

    // ----------------------------------------
    // delay matching and output stage
    // ----------------------------------------
    // pipes are flushed while held so no stale frame leaks out on release
    vmu_dly #(.W(3*OW), .D(`VMU_LAT - 5)) u_px_dly (
        .clk_i(clk_i),
        .clr_i(sys_rst_i | hold_now),
        .ce_i(ce_i),
        .d_i(px_s4),
        .q_o(px_q)
    );

    vmu_dly #(.W(3), .D(`VMU_LAT - 1)) u_sync_dly (
        .clk_i(clk_i),
        .clr_i(sys_rst_i | hold_now),
        .ce_i(ce_i),
        .d_i({active_video_i, vblank_i, hblank_i}),
        .q_o(sync_q)
    );

    // last of the seven stages; zeroing wins over the clock enable
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || zero_w) begin
            {pix_b_o, pix_g_o, pix_r_o} <= '0;
            {active_video_o, vblank_o, hblank_o} <= 3'h0;
        end else if (ce_i) begin
            {pix_b_o, pix_g_o, pix_r_o} <= px_q;
            {active_video_o, vblank_o, hblank_o} <= sync_q;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_hold_zero_out: assert property (rst_r[`VMU_RST_MAN] |=> ({pix_r_o, pix_g_o, pix_b_o} == '0)
        && !hblank_o && !vblank_o && !active_video_o) else $error("outputs not zero in reset");
    a_man_rst_now: assert property ($rose(rst_r[`VMU_RST_MAN]) |=> state_r == ST_HOLD)
        else $error("manual reset did not act at once");
    a_rst_defaults: assert property (state_r == ST_HOLD |-> tw_stg[0] == `VMU_K_ONE
        && tw_act[`VMU_TW_CLIP] == `VMU_CLIP_DEF && ctl_r == `VMU_CTL_DEF) else $error("defaults not restored");
    a_resync_edge: assert property (state_r == ST_RESYNC && !vb_rise && !hold_now |=> state_r == ST_RESYNC)
        else $error("left resync without frame edge");
    a_apply_vblank: assert property (apply_w |=> tw_act[1] == $past(tw_stg[1]))
        else $error("staged value not applied");
    a_keep_live: assert property (!apply_w && !hold_now |=> $stable(tw_act))
        else $error("live values moved without apply");
    a_upd_gated: assert property (wr_ctl && !ctl_r[`VMU_CTL_EN] && !hold_now |=> $stable(ctl_r[`VMU_CTL_UPD]))
        else $error("update bit changed while disabled");
    a_all_together: assert property (apply_w |=> tw_act[`VMU_TW_OFS0] == $past(tw_stg[`VMU_TW_OFS0])
        && tw_act[`VMU_TW_CLAMP] == $past(tw_stg[`VMU_TW_CLAMP]) && tw_act[8] == $past(tw_stg[8]))
        else $error("tuning words not applied together");
    a_sync_latency: assert property ((ce_i && !zero_w)[*8] |->
        {active_video_o, vblank_o, hblank_o} == $past({active_video_i, vblank_i, hblank_i}, 7))
        else $error("sync latency is not seven");
    a_ce_freeze: assert property (!ce_i && !zero_w |=> $stable({pix_r_o, pix_g_o, pix_b_o, vblank_o}))
        else $error("outputs moved with ce low");
    a_eval_stop: assert property (expired_r |=> expired_r && pix_g_o == '0 && !vblank_o)
        else $error("evaluation stop not permanent");
    a_part_word: assert property (wr_go && wstrb_r != `VMU_FULL_STRB |=> $stable(rst_r))
        else $error("partial write took effect");

    c_apply: cover property (apply_w);
    c_hold_run: cover property (state_r == ST_HOLD ##[1:1000] state_r == ST_RUN);
    c_ce_gap: cover property (state_r == ST_RUN && !ce_i);
endmodule

// file: sim/vmu_vid_src.sv
`timescale 1ns/1ns
// ----------------------------------------
// upstream video timing source, 16x8 raster
// ----------------------------------------
module vmu_vid_src (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic ce_i,
    output logic hblank_o,
    output logic vblank_o,
    output logic active_o
);
    logic [3:0] h_r;
    logic [2:0] v_r;

    // raster counters; ce low freezes the raster so the stream is throttled
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            h_r <= 4'h0;
            v_r <= 3'h0;
        end else if (ce_i) begin
            h_r <= h_r + 4'h1;
            if (h_r == 4'hF) v_r <= v_r + 3'h1;
        end
    end

    // last four pixels of a line and last two lines are blanking
    assign hblank_o = h_r >= 4'hC;
    assign vblank_o = v_r >= 3'h6;
    assign active_o = !hblank_o && !vblank_o;
endmodule

// file: sim/video_matrix_update_ctrl_test.sv
`timescale 1ns/1ns
`include "vmu_cfg.svh"
module video_matrix_update_ctrl_test;
    import vmu_pkg::*;
    localparam logic [39:0] EVC = 40'd20000;
    localparam logic [1:0] OK = `VMU_RESP_OK;
    localparam logic [3:0] FS = `VMU_FULL_STRB;
    logic clk_i = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b0;
    logic [7:0] pr = 8'h00, pg = 8'h00, pb = 8'h00, awa = 8'h00, ara = 8'h00;
    logic awv = 1'b0, wv = 1'b0, arv = 1'b0, hb, vb, av, ohb, ovb, oav, awr, wrd, bv, arr, rv, vb_q;
    logic [31:0] wd = 32'h0, rdat;
    logic [3:0] ws = 4'h0;
    logic [11:0] orr, og, ob;
    logic [1:0] br, rr;
    vmu_state_t st;
    logic [39:0] hist[$], e;
    integer seed = 2149, num_errors = 0, n_checks = 0, cyc = 0;
    int k[9], ofs[3], clp, clm, sk[9], sofs[3], sclp, sclm, ctl, mode, rc, nc, arst = 0, chk_on = 1;

    // 20 MHz clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    vmu_top #(.EVAL_CYCLES(EVC), .EVAL_BUILD(1'b1)) u_dut (
        .clk_i(clk_i), .sys_rst_i(rst), .ce_i(ce), .pix_r_i(pr), .pix_g_i(pg), .pix_b_i(pb),
        .hblank_i(hb), .vblank_i(vb), .active_video_i(av), .pix_r_o(orr), .pix_g_o(og), .pix_b_o(ob),
        .hblank_o(ohb), .vblank_o(ovb), .active_video_o(oav), .state_o(st),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(br),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(1'b1));
    vmu_vid_src u_src (.clk_i(clk_i), .clr_i(rst), .ce_i(ce), .hblank_o(hb), .vblank_o(vb), .active_o(av));

    // random pixels and throttling, about one ce in eight dropped
    always @(posedge clk_i) begin
        pr <= 8'($random(seed));
        pg <= 8'($random(seed));
        pb <= 8'($random(seed));
        ce <= ($random(seed) & 7) != 0;
    end

    // ----------------------------------------
    // reference model
    // ----------------------------------------
    function automatic logic [11:0] px(int c, int r, int g, int b);
        int v;
        v = ((k[3*c] * r + k[3*c+1] * g + k[3*c+2] * b) >>> 11) + ofs[c];
        if (v > clp) v = clp;
        if (v < clm) v = clm;
        return 12'(v);
    endfunction

    function automatic void dflt();
        foreach (k[i]) k[i] = (i % 4 == 0) ? `VMU_K_ONE : 0;
        ofs = '{0, 0, 0};
        clp = 32'hFFF;
        clm = 0;
        sk = k;
        sofs = ofs;
        sclp = clp;
        sclm = clm;
        ctl = 1;
    endfunction

    // samples what the design samples; blanking pixels skipped since the apply edge lies there
    always @(posedge clk_i) begin
        cyc = rst ? 0 : cyc + 1;
        if (rst) begin
            mode = 2;
            vb_q = 1'b0;
            hist.delete();
            dflt();
        end else if (ce) begin
            if (vb && !vb_q && arst != 0) mode = 1;
            else if (vb && !vb_q && mode == 2) mode = 0;
            else if (vb && !vb_q && mode == 0 && ctl == 3) begin
                k = sk;
                ofs = sofs;
                clp = sclp;
                clm = sclm;
            end
            vb_q = vb;
            hist.push_back({vb, hb, vb, av, px(0, pr, pg, pb), px(1, pr, pg, pb), px(2, pr, pg, pb)});
            if (hist.size() > 8) void'(hist.pop_front());
        end
        nc = (mode == 0) ? 0 : nc + 1;
        rc = (mode != 0) ? 0 : rc + ce;
        #1;
        if (chk_on != 0 && mode == 0 && rc >= 8) begin
            e = hist[hist.size() - 7];
            chk({ohb, ovb, oav}, e[38:36]);
            if (!e[39] && !e[38]) chk({orr, og, ob}, e[35:0]);
        end
        if (chk_on != 0 && mode != 0 && nc >= 5) chk({orr, og, ob, ohb, ovb, oav}, 0);
    end

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic chk(input logic [39:0] s, input logic [39:0] x);
        n_checks++;
        if (s !== x) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic tmo();
        num_errors++;
        complete_run();
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
            if (bv) break;
        end
        chk(br, er);
        if (n == 50) tmo();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        ara <= a;
        arv <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (arv && arr) arv <= 1'b0;
            if (rv) break;
        end
        d = rdat;
        r = rr;
        if (n == 50) tmo();
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, x);
        chk(r, er);
    endtask

    // waits past the next vblank fall, far from the following rise
    task automatic sync_vb();
        int n;
        logic seen;
        seen = 1'b0;
        for (n = 0; n < 600; n++) begin
            @(posedge clk_i);
            if (vb) seen = 1'b1;
            else if (seen) break;
        end
        if (n == 600) tmo();
    endtask

    // random tuning words; clip kept high so results are not all flat
    task automatic stage();
        int v;
        for (int i = 0; i < 14; i++) begin
            v = $random(seed) & 32'hFFFF;
            if (i >= 9) v = v & 32'h1FFF;
            if (i >= 12) v = v & 32'h1FF;
            if (i == 12) v = v | 32'hE00;
            if (i < 9) sk[i] = $signed(16'(v));
            else if (i < 12) sofs[i - 9] = $signed(13'(v));
            else if (i == 12) sclp = v;
            else sclm = v;
            wr(8'(`VMU_OFF_TW0 + 4 * i), v, FS, OK);
            rdc(8'(`VMU_OFF_TW0 + 4 * i), v, OK);
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int i;
        repeat (6) @(posedge clk_i);
        rst <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(st, ST_RESYNC);
        rdc(`VMU_OFF_CTL, `VMU_CTL_DEF, OK);
        rdc(`VMU_OFF_RST, 0, OK);
        rdc(`VMU_OFF_STAT, 32'h2, OK);
        sync_vb();
        sync_vb();
        chk(st, ST_RUN);
        rdc(`VMU_OFF_STAT, 32'h8, OK);
        for (i = 0; i < 3; i++) begin
            d = (i == 0) ? 0 : i + 1;
            wr(`VMU_OFF_CTL, d, FS, OK);
            ctl = (ctl[0] ? (d & 2) : (ctl & 2)) | (d & 1);
            rdc(`VMU_OFF_CTL, ctl, OK);
        end
        stage();
        sync_vb();
        sync_vb();
        wr(`VMU_OFF_CTL, 3, FS, OK);
        ctl = 3;
        sync_vb();
        sync_vb();
        wr(`VMU_OFF_CTL, 1, FS, OK);
        ctl = 1;
        stage();
        sync_vb();
        sync_vb();
        wr(`VMU_OFF_TW0, 32'h1234, 4'h3, OK);
        rdc(`VMU_OFF_TW0, sk[0] & 32'hFFFF, OK);
        wr(8'h48, 32'h5, FS, `VMU_RESP_ERR);
        rdc(8'h48, 0, `VMU_RESP_ERR);
        wr(`VMU_OFF_STAT, 32'hFFFFFFFF, FS, OK);
        rdc(`VMU_OFF_STAT, 32'h8, OK);
        mode = 1;
        dflt();
        wr(`VMU_OFF_RST, 1, FS, OK);
        repeat (6) @(posedge clk_i);
        chk(st, ST_HOLD);
        wr(`VMU_OFF_TW0, 0, FS, OK);
        rdc(`VMU_OFF_TW0, `VMU_K_ONE, OK);
        rdc(`VMU_OFF_CTL, 1, OK);
        rdc(`VMU_OFF_STAT, 1, OK);
        sync_vb();
        mode = 2;
        wr(`VMU_OFF_RST, 0, FS, OK);
        rdc(`VMU_OFF_STAT, 2, OK);
        sync_vb();
        sync_vb();
        chk(st, ST_RUN);
        arst = 1;
        wr(`VMU_OFF_RST, 2, FS, OK);
        sync_vb();
        chk(st, ST_HOLD);
        mode = 2;
        arst = 0;
        wr(`VMU_OFF_RST, 0, FS, OK);
        sync_vb();
        sync_vb();
        chk(st, ST_RUN);
        chk_on = 0;
        d = 0;
        for (i = 0; i < 20000 && !d[2]; i++) rd(`VMU_OFF_STAT, d, r);
        chk({d[2], cyc >= EVC}, 2'b11);
        mode = 3;
        chk_on = 1;
        repeat (10) @(posedge clk_i);
        complete_run();
    end
endmodule
